// >>> logic/sdm_defs.vh
// Purpose: Shared constants of the sector defect manager
// Assumes: Addresses are {track[23:0], sector[7:0]}
// Notes: Definitions only
`ifndef SDM_DEFS_VH
`define SDM_DEFS_VH

// ==========================================================
// Disk definition record content
`define SDM_REC_ID 8'h0a
`define SDM_MEDIA_ID 8'h00
`define SDM_CERT_YES 8'h01
`define SDM_CERT_NO 8'h02
`define SDM_GRP_MSB 8'h00
`define SDM_GRP_LSB 8'h13
`define SDM_GRP_RW 8'h01
`define SDM_B40 8'h01
`define SDM_FILL 8'h00
`define SDM_B_PDL 11'h00e
`define SDM_B_SDL 11'h012
`define SDM_B_GRP0 11'h016
`define SDM_B_GRP17 11'h027
`define SDM_B_PAD 11'h028
`define SDM_REC_LAST 11'h7ff
`define SDM_COPY_LAST 2'h3

// ==========================================================
// Zone, groups and limits
`define SDM_NGROUPS 18
`define SDM_NGRP5 5'h12
`define SDM_ZONE_FIRST 24'h000003
`define SDM_ZONE_LAST 24'h008fdc
`define SDM_SPT 9'h011
`define SDM_MAX_REPL 16'h1155
`define SDM_LIST_FILL 32'hffffffff

// ==========================================================
// Register offsets
`define SDM_R_CTRL 8'h00
`define SDM_R_STAT 8'h04
`define SDM_R_PDLST 8'h08
`define SDM_R_SDLST 8'h0c
`define SDM_R_GSEL 8'h10
`define SDM_R_GNEXT 8'h14
`define SDM_R_GLEFT 8'h18
`define SDM_R_DEFECT 8'h1c
`define SDM_R_GDONE 8'h20
`define SDM_R_XLIN 8'h24
`define SDM_R_XLOUT 8'h28
`define SDM_R_SPDEF 8'h2c
`define SDM_R_LIDX 8'h30
`define SDM_R_PDLENT 8'h34
`define SDM_R_SDLDEF 8'h38
`define SDM_R_SDLREP 8'h3c

// ==========================================================
// Control bits
`define SDM_C_CERT 0
`define SDM_C_GO 1
`define SDM_C_CLR 2
`define SDM_C_CACT 3
`endif

// >>> logic/sdm_rec_gen.v
// Purpose: Byte generator of the one-sector disk definition record
// Assumes: Inputs stable while a record is emitted
// Notes: Purely combinational
`timescale 1ns/1ps
`include "sdm_defs.vh"

module sdm_rec_gen (
    // Byte select
    input wire [10:0] idx_i,
    // Record parameters
    input wire cert_i,
    input wire [31:0] pdl_start_i,
    input wire [31:0] sdl_start_i,
    // Byte out
    output reg [7:0] byte_o
);

    always @* begin
        byte_o = `SDM_FILL;
        if (idx_i <= 11'h001) begin
            byte_o = `SDM_REC_ID;
        end else if (idx_i == 11'h002) begin
            byte_o = `SDM_MEDIA_ID;
        end else if (idx_i == 11'h003) begin
            byte_o = cert_i ? `SDM_CERT_YES : `SDM_CERT_NO;
        end else if (idx_i == 11'h004) begin
            byte_o = `SDM_GRP_MSB;
        end else if (idx_i == 11'h005) begin
            byte_o = `SDM_GRP_LSB;
        end else if (idx_i >= `SDM_B_PDL && idx_i < `SDM_B_SDL) begin
            // Track MSB first, sector last
            byte_o = pdl_start_i[8'd31 - {idx_i[1:0] - 2'h2, 3'h0} -: 8];
        end else if (idx_i >= `SDM_B_SDL && idx_i < `SDM_B_GRP0) begin
            byte_o = sdl_start_i[8'd31 - {idx_i[1:0] - 2'h2, 3'h0} -: 8];
        end else if (idx_i >= `SDM_B_GRP0 && idx_i <= `SDM_B_GRP17) begin
            byte_o = `SDM_GRP_RW;
        end else if (idx_i == `SDM_B_PAD) begin
            byte_o = `SDM_B40;
        end
    end

endmodule // sdm_rec_gen

// >>> logic/sdm_list.v
// Purpose: Defect list store with key and data lookup
// Assumes: Entries are appended only
// Notes: 16 entries; unused entries read as all ones
`timescale 1ns/1ps
`include "sdm_defs.vh"

module sdm_list (
    // Clock and reset
    input wire clk_sys_i,
    input wire rst_n_i,
    // Update
    input wire clr_i,
    input wire add_i,
    input wire [31:0] key_i,
    input wire [31:0] dat_i,
    // Lookup
    input wire [31:0] probe_i,
    input wire [3:0] rd_idx_i,
    // Results
    output wire [4:0] count_o,
    output wire [31:0] last_key_o,
    output reg hit_k_o,
    output reg [31:0] hit_k_dat_o,
    output reg hit_d_o,
    output reg [31:0] hit_d_key_o,
    output reg [4:0] le_cnt_o,
    output wire [31:0] rd_key_o,
    output wire [31:0] rd_dat_o
);

    reg [31:0] key_q [0:15];
    reg [31:0] dat_q [0:15];
    reg [4:0] cnt_q;
    wire [15:0] vld;
    wire [15:0] hk;
    wire [15:0] hd;
    wire [15:0] le;
    integer i;

    genvar gi;
    generate
        for (gi = 0; gi < 16; gi = gi + 1) begin : g_ent
            assign vld[gi] = (gi < cnt_q);
            assign hk[gi] = vld[gi] && (key_q[gi] == probe_i);
            assign hd[gi] = vld[gi] && (dat_q[gi] == probe_i);
            assign le[gi] = vld[gi] && (key_q[gi] <= probe_i);
            always @(posedge clk_sys_i or negedge rst_n_i) begin
                if (!rst_n_i) begin
                    key_q[gi] <= `SDM_LIST_FILL;
                    dat_q[gi] <= `SDM_LIST_FILL;
                end else if (clr_i) begin
                    key_q[gi] <= `SDM_LIST_FILL;
                    dat_q[gi] <= `SDM_LIST_FILL;
                end else if (add_i && cnt_q == gi) begin
                    key_q[gi] <= key_i;
                    dat_q[gi] <= dat_i;
                end
            end
        end
    endgenerate

    always @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cnt_q <= 5'h00;
        end else if (clr_i) begin
            cnt_q <= 5'h00;
        end else if (add_i && !cnt_q[4]) begin
            cnt_q <= cnt_q + 5'h01;
        end
    end

    // Latest match wins, so a newer reassignment overrides older ones
    always @* begin
        hit_k_o = 1'b0;
        hit_k_dat_o = `SDM_LIST_FILL;
        hit_d_o = 1'b0;
        hit_d_key_o = `SDM_LIST_FILL;
        le_cnt_o = 5'h00;
        for (i = 0; i < 16; i = i + 1) begin
            if (hk[i]) begin
                hit_k_o = 1'b1;
                hit_k_dat_o = dat_q[i];
            end
            if (hd[i]) begin
                hit_d_o = 1'b1;
                hit_d_key_o = key_q[i];
            end
            le_cnt_o = le_cnt_o + {4'h0, le[i]};
        end
    end

    assign count_o = cnt_q;
    assign last_key_o = (cnt_q == 5'h00) ? 32'h00000000 : key_q[cnt_q[3:0] - 4'h1];
    assign rd_key_o = key_q[rd_idx_i];
    assign rd_dat_o = dat_q[rd_idx_i];

endmodule // sdm_list

// >>> logic/sdm_top.v
// Purpose: Defect management of a rewritable optical cartridge
// Assumes: Register strobes one cycle, never together
// Notes: Group of a reported defect is the selected group
//
// Design decisions made here: the placing of the registers and the plain strobed port.
`timescale 1ns/1ps
`include "sdm_defs.vh"

// Behaviour
// - Emit one-sector record at initialization end
// - Identifier 0a 0a, media 00, zeros 6-13
// - Byte 3 certified flag selects method
// - Group count bytes 00 then 13
// - List start addresses, track MSB first
// - Group types bytes 22-39 all 01
// - Zone spans tracks 3 to 36828
// - Eighteen groups, one per band
// - Spares used only to substitute defects
// - Total replaced sectors never exceed 4437
// - Four identical record copies and lists; only the record is streamed, each list is held once
// - Certified defects excluded from all access
// - Certification slips data, logs primary list
// - Bad spares logged, reduce spare count; the code logs a bad spare in the primary list only while cact_q is set
// - Exhausted group borrows from certified group
// - Linear: own spare else other group
// - Primary-listed addresses never enter secondary
// - Bad replacement gets new secondary entry
// - Uncertified disks still skip primary entries
// - Writes skip primary-listed sectors
// - Secondary-listed writes go to spare
// - Primary list ascending, unused reads ff
// - Secondary entry is defect/replacement pair
module sdm_top (
    // Clock and reset
    input wire clk_sys_i,
    input wire rst_n_i,
    // Register port
    input wire [7:0] reg_addr_i,
    input wire [31:0] reg_wdata_i,
    input wire reg_wr_i,
    input wire reg_rd_i,
    output reg [31:0] reg_rdata_o,
    // Record stream toward the write channel
    output wire rec_valid_o,
    input wire rec_ready_i,
    output reg [7:0] rec_byte_o,
    output reg [1:0] rec_copy_o,
    output reg [10:0] rec_index_o,
    output wire rec_last_o
);

    // ======================================================
    // Declarations
    localparam ST_IDLE = 1'b0;
    localparam ST_SEND = 1'b1;

    reg state_q, cert_q, cact_q;
    reg [31:0] pdl_st_q, sdl_st_q, xlin_q;
    reg [4:0] gsel_q;
    reg [17:0] gdone_q;
    reg [3:0] lidx_q;
    reg [15:0] total_q;
    reg e_zone_q, e_ovf_q, e_ord_q, e_nosp_q;
    reg [31:0] gnext_q [0:17];
    reg [15:0] gleft_q [0:17];
    reg [10:0] idx_d;
    reg pdl_add, sdl_add, cons, decr;
    reg [4:0] cons_g, alt_g;
    reg [31:0] sdl_key, rd_val;
    reg e_zone, e_ovf, e_ord, e_nosp, alt_ok;
    integer j;

    wire wr_ctrl = reg_wr_i && (reg_addr_i == `SDM_R_CTRL);
    wire wr_def = reg_wr_i && (reg_addr_i == `SDM_R_DEFECT);
    wire wr_spd = reg_wr_i && (reg_addr_i == `SDM_R_SPDEF);
    wire wr_stat = reg_wr_i && (reg_addr_i == `SDM_R_STAT);
    wire go = wr_ctrl && reg_wdata_i[`SDM_C_GO];
    wire clr = wr_ctrl && reg_wdata_i[`SDM_C_CLR];
    wire busy = (state_q == ST_SEND);
    wire acc = busy && rec_ready_i;
    wire at_end = (rec_index_o == `SDM_REC_LAST);
    wire [31:0] d_addr = reg_wdata_i;
    wire [4:0] g = gsel_q;
    wire g_ok = (g < `SDM_NGRP5);
    wire own_ok = g_ok && (gleft_q[g] != 16'h0000);
    wire [7:0] gen_byte;
    wire [4:0] pdl_cnt, pdl_le, sdl_cnt;
    wire pdl_hit, sdl_hk, sdl_hd;
    wire [31:0] pdl_last, pdl_rd, sdl_hk_dat, sdl_hd_key, sdl_rd_k, sdl_rd_d;

    // Zone bounds exclude both list areas at the disk edges
    wire zone_ok = (d_addr[31:8] >= `SDM_ZONE_FIRST) &&
                   (d_addr[31:8] <= `SDM_ZONE_LAST);

    // Advance an address by k sectors, wrapping at the track end
    function [31:0] sdm_adv;
        input [31:0] a;
        input [4:0] k;
        reg [8:0] s;
        begin
            s = {1'b0, a[7:0]} + {4'h0, k};
            if (s >= `SDM_SPT) begin
                sdm_adv = {a[31:8] + 24'h000001, s[7:0] - 8'h11};
            end else begin
                sdm_adv = {a[31:8], s[7:0]};
            end
        end
    endfunction

    // ======================================================
    // Record stream
    always @* begin
        if (!busy) begin
            idx_d = 11'h000;
        end else if (acc) begin
            idx_d = at_end ? 11'h000 : rec_index_o + 11'h001;
        end else begin
            idx_d = rec_index_o;
        end
    end

    sdm_rec_gen u_gen (
        .idx_i(idx_d),
        .cert_i(cert_q),
        .pdl_start_i(pdl_st_q),
        .sdl_start_i(sdl_st_q),
        .byte_o(gen_byte)
    );

    always @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_q <= ST_IDLE;
            rec_copy_o <= 2'h0;
            rec_index_o <= 11'h000;
            rec_byte_o <= 8'h00;
        end else begin
            rec_byte_o <= gen_byte;
            rec_index_o <= idx_d;
            case (state_q)
                ST_IDLE: begin
                    rec_copy_o <= 2'h0;
                    if (go) state_q <= ST_SEND;
                end
                ST_SEND: begin
                    // Same sector sent once per management area
                    if (acc && at_end) begin
                        if (rec_copy_o == `SDM_COPY_LAST) begin
                            state_q <= ST_IDLE;
                        end else begin
                            rec_copy_o <= rec_copy_o + 2'h1;
                        end
                    end
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    assign rec_valid_o = busy;
    assign rec_last_o = busy && at_end && (rec_copy_o == `SDM_COPY_LAST);

    // ======================================================
    // Defect lists
    // Probes share a port: a defect write uses its own address
    wire probe_def = wr_def || wr_spd;
    wire [31:0] pdl_probe = probe_def ? d_addr : xlin_q;
    wire [31:0] slip = sdm_adv(xlin_q, pdl_le);
    wire [31:0] sdl_probe = probe_def ? d_addr : slip;
    wire [31:0] xlout = sdl_hk ? sdl_hk_dat : slip;

    sdm_list u_pdl (
        .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .clr_i(clr), .add_i(pdl_add),
        .key_i(d_addr), .dat_i(d_addr), .probe_i(pdl_probe), .rd_idx_i(lidx_q),
        .count_o(pdl_cnt), .last_key_o(pdl_last), .hit_k_o(pdl_hit), .hit_k_dat_o(),
        .hit_d_o(), .hit_d_key_o(), .le_cnt_o(pdl_le), .rd_dat_o(),
        .rd_key_o(pdl_rd)
    );

    sdm_list u_sdl (
        .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .clr_i(clr), .add_i(sdl_add),
        .key_i(sdl_key), .probe_i(sdl_probe), .rd_idx_i(lidx_q),
        .dat_i(gnext_q[cons_g]),
        .count_o(sdl_cnt), .last_key_o(), .hit_k_o(sdl_hk), .hit_k_dat_o(sdl_hk_dat),
        .hit_d_o(sdl_hd), .hit_d_key_o(sdl_hd_key), .le_cnt_o(),
        .rd_key_o(sdl_rd_k), .rd_dat_o(sdl_rd_d)
    );

    // ======================================================
    // Replacement decision
    // While certifying, only a finished group may lend a spare
    always @* begin
        alt_ok = 1'b0;
        alt_g = 5'h00;
        for (j = `SDM_NGROUPS - 1; j >= 0; j = j - 1) begin
            if (gleft_q[j] != 16'h0000 && (gdone_q[j] || !cact_q)) begin
                alt_ok = 1'b1;
                alt_g = j[4:0];
            end
        end
    end

    always @* begin
        pdl_add = 1'b0;
        sdl_add = 1'b0;
        cons = 1'b0;
        cons_g = g;
        decr = 1'b0;
        sdl_key = d_addr;
        e_zone = 1'b0;
        e_ovf = 1'b0;
        e_ord = 1'b0;
        e_nosp = 1'b0;
        if (probe_def) begin
            if (!zone_ok || !g_ok) begin
                e_zone = 1'b1;
            end else if (pdl_hit) begin
                e_zone = 1'b0;
            end else if (total_q >= `SDM_MAX_REPL) begin
                e_ovf = 1'b1;
            end else if (wr_spd) begin
                decr = own_ok;
                pdl_add = cact_q;
                if (own_ok && d_addr == gnext_q[g]) begin
                    decr = 1'b0;
                    cons = 1'b1;
                end
            end else if (cact_q && own_ok) begin
                pdl_add = 1'b1;
                cons = 1'b1;
            end else begin
                if (sdl_hd) sdl_key = sdl_hd_key;
                if (own_ok && !cact_q) begin
                    cons = 1'b1;
                    sdl_add = 1'b1;
                end else if (alt_ok) begin
                    cons = 1'b1;
                    cons_g = alt_g;
                    sdl_add = 1'b1;
                end else begin
                    e_nosp = 1'b1;
                end
            end
            if (pdl_add && pdl_cnt != 5'h00 && d_addr <= pdl_last) begin
                pdl_add = 1'b0;
                cons = 1'b0;
                decr = 1'b0;
                e_ord = 1'b1;
            end
            if ((pdl_add && pdl_cnt[4]) || (sdl_add && sdl_cnt[4])) begin
                pdl_add = 1'b0;
                sdl_add = 1'b0;
                cons = 1'b0;
                decr = 1'b0;
                e_ovf = 1'b1;
            end
        end
    end

    // ======================================================
    // Per-group spare pointers, one band per group
    genvar gi;
    generate
        for (gi = 0; gi < `SDM_NGROUPS; gi = gi + 1) begin : g_grp
            always @(posedge clk_sys_i or negedge rst_n_i) begin
                if (!rst_n_i) begin
                    gnext_q[gi] <= 32'h00000000;
                    gleft_q[gi] <= 16'h0000;
                end else if (cons && cons_g == gi) begin
                    gnext_q[gi] <= sdm_adv(gnext_q[gi], 5'h01);
                    gleft_q[gi] <= gleft_q[gi] - 16'h0001;
                end else if (decr && g == gi) begin
                    gleft_q[gi] <= gleft_q[gi] - 16'h0001;
                end else if (reg_wr_i && g == gi) begin
                    if (reg_addr_i == `SDM_R_GNEXT) gnext_q[gi] <= reg_wdata_i;
                    if (reg_addr_i == `SDM_R_GLEFT) gleft_q[gi] <= reg_wdata_i[15:0];
                end
            end
        end
    endgenerate

    // ======================================================
    // Control and status registers
    // Record parameters freeze while copies go out
    always @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cert_q <= 1'b0;
            cact_q <= 1'b0;
            pdl_st_q <= 32'h00000000;
            sdl_st_q <= 32'h00000000;
            gsel_q <= 5'h00;
            gdone_q <= 18'h00000;
            xlin_q <= 32'h00000000;
            lidx_q <= 4'h0;
        end else if (reg_wr_i) begin
            case (reg_addr_i)
                `SDM_R_CTRL: begin
                    cact_q <= reg_wdata_i[`SDM_C_CACT];
                    if (!busy) cert_q <= reg_wdata_i[`SDM_C_CERT];
                end
                `SDM_R_PDLST: if (!busy) pdl_st_q <= reg_wdata_i;
                `SDM_R_SDLST: if (!busy) sdl_st_q <= reg_wdata_i;
                `SDM_R_GSEL: gsel_q <= reg_wdata_i[4:0];
                `SDM_R_GDONE: gdone_q <= reg_wdata_i[17:0];
                `SDM_R_XLIN: xlin_q <= reg_wdata_i;
                `SDM_R_LIDX: lidx_q <= reg_wdata_i[3:0];
                default: lidx_q <= lidx_q;
            endcase
        end
    end

    // Sticky errors: a new event beats a clear in the same cycle
    always @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            total_q <= 16'h0000;
            e_zone_q <= 1'b0;
            e_ovf_q <= 1'b0;
            e_ord_q <= 1'b0;
            e_nosp_q <= 1'b0;
        end else begin
            if (clr) begin
                total_q <= 16'h0000;
            end else if (pdl_add || sdl_add) begin
                total_q <= total_q + 16'h0001;
            end
            e_zone_q <= e_zone | (e_zone_q & ~(wr_stat & reg_wdata_i[1]));
            e_ovf_q <= e_ovf | (e_ovf_q & ~(wr_stat & reg_wdata_i[2]));
            e_ord_q <= e_ord | (e_ord_q & ~(wr_stat & reg_wdata_i[3]));
            e_nosp_q <= e_nosp | (e_nosp_q & ~(wr_stat & reg_wdata_i[4]));
        end
    end

    // ======================================================
    // Read path
    always @* begin
        case (reg_addr_i)
            `SDM_R_CTRL: rd_val = {28'h0, cact_q, 2'b00, cert_q};
            `SDM_R_STAT: rd_val = {total_q, 1'b0, sdl_cnt, pdl_cnt,
                                   e_nosp_q, e_ord_q, e_ovf_q, e_zone_q, busy};
            `SDM_R_PDLST: rd_val = pdl_st_q;
            `SDM_R_SDLST: rd_val = sdl_st_q;
            `SDM_R_GSEL: rd_val = {27'h0, gsel_q};
            `SDM_R_GNEXT: rd_val = g_ok ? gnext_q[g] : 32'h00000000;
            `SDM_R_GLEFT: rd_val = g_ok ? {16'h0, gleft_q[g]} : 32'h00000000;
            `SDM_R_GDONE: rd_val = {14'h0, gdone_q};
            `SDM_R_XLIN: rd_val = xlin_q;
            `SDM_R_XLOUT: rd_val = xlout;
            `SDM_R_LIDX: rd_val = {28'h0, lidx_q};
            `SDM_R_PDLENT: rd_val = pdl_rd;
            `SDM_R_SDLDEF: rd_val = sdl_rd_k;
            `SDM_R_SDLREP: rd_val = sdl_rd_d;
            default: rd_val = 32'h00000000;
        endcase
    end

    always @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            reg_rdata_o <= 32'h00000000;
        end else begin
            reg_rdata_o <= reg_rd_i ? rd_val : 32'h00000000;
        end
    end

endmodule // sdm_top

// >>> sim/sdm_monitor.sv
// Purpose: Assertions on the record stream of the defect manager
// Assumes: Sees only top-level ports
// Notes: Byte values come from the fixed record layout
`timescale 1ns/1ps
module sdm_monitor (
    // Clock and reset
    input wire clk_sys_i,
    input wire rst_n_i,
    // Record stream
    input wire rec_valid_o,
    input wire rec_ready_i,
    input wire [7:0] rec_byte_o,
    input wire [1:0] rec_copy_o,
    input wire [10:0] rec_index_o,
    input wire rec_last_o
);
    // ==========================================
    // Record content and order
    default clocking mcb @(posedge clk_sys_i);
    endclocking
    default disable iff (!rst_n_i);
    a_rec_ident: assert property (
        rec_valid_o && rec_index_o < 11'h002 |-> rec_byte_o == 8'h0a) else $error("bad id byte");
    a_rec_zeros: assert property (
        rec_valid_o && (rec_index_o == 11'h002 || rec_index_o == 11'h004
        || (rec_index_o >= 11'h006 && rec_index_o <= 11'h00d)) |-> rec_byte_o == 8'h00)
        else $error("bad zero byte");
    a_grp_count: assert property (
        rec_valid_o && rec_index_o == 11'h005 |-> rec_byte_o == 8'h13) else $error("bad count");
    a_cert_flag: assert property (
        rec_valid_o && rec_index_o == 11'h003 |-> rec_byte_o inside {8'h01, 8'h02})
        else $error("bad cert byte");
    a_grp_types: assert property (
        rec_valid_o && rec_index_o >= 11'h016 && rec_index_o <= 11'h028 |-> rec_byte_o == 8'h01)
        else $error("bad group type");
    a_pad_fill: assert property (
        rec_valid_o && rec_index_o > 11'h028 |-> rec_byte_o == 8'h00) else $error("bad pad");
    a_idx_step: assert property (
        rec_valid_o && rec_ready_i && rec_index_o != 11'h7ff |=> rec_valid_o
        && rec_index_o == $past(rec_index_o) + 11'h001 && $stable(rec_copy_o))
        else $error("index skipped");
    a_copy_step: assert property (
        rec_valid_o && rec_ready_i && rec_index_o == 11'h7ff && !rec_last_o |=> rec_valid_o
        && rec_index_o == 11'h000 && rec_copy_o == $past(rec_copy_o) + 2'h1)
        else $error("copy not advanced");
    a_last_pos: assert property (
        rec_last_o |-> rec_valid_o && rec_index_o == 11'h7ff && rec_copy_o == 2'h3)
        else $error("last misplaced");
    a_stream_end: assert property (
        rec_last_o && rec_ready_i |=> !rec_valid_o [*2]) else $error("stream overran");
    a_byte_hold: assert property (
        rec_valid_o && !rec_ready_i |=> rec_valid_o && $stable(rec_byte_o)
        && $stable(rec_index_o)) else $error("byte dropped");
endmodule // sdm_monitor

// >>> sim/sdm_sink.sv
// Purpose: Write-channel model taking the record stream
// Assumes: Ready may drop in any cycle
// Notes: slow_i stalls about half the time
`timescale 1ns/1ps
module sdm_sink (
    // Clock and reset
    input wire clk_sys_i,
    input wire rst_n_i,
    // Stream control
    input wire slow_i,
    output reg ready_o
);
    // ==========================================
    // Ready generation
    always @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ready_o <= 1'b0;
        end else begin
            ready_o <= !slow_i || ($urandom % 2 == 0);
        end
    end
endmodule // sdm_sink

// >>> sim/test_sector_defect_manager.sv
// Purpose: Self-checking bench of the sector defect manager
// Assumes: Write channel modelled by sdm_sink
// Notes: Record bytes predicted by exp_byte, lists predicted from queues
`timescale 1ns/1ps
module test_sector_defect_manager;
    reg clk_sys_i = 0, rst_n_i = 0, reg_wr_i = 0, reg_rd_i = 0, slow = 0;
    reg [7:0] reg_addr_i = 8'h00;
    reg [31:0] reg_wdata_i = 32'h0, v, a, d, sp;
    wire [31:0] reg_rdata_o;
    wire [7:0] rec_byte_o;
    wire [1:0] rec_copy_o;
    wire [10:0] rec_index_o;
    wire rec_valid_o, rec_ready_i, rec_last_o;
    int failures = 0, checks_done = 0, n, i, k;
    logic [31:0] pq[$], sk[$], sr[$];
    // ==========================================
    // Design, channel model, clock
    sdm_top uut (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr_i),
        .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
        .reg_rdata_o(reg_rdata_o), .rec_valid_o(rec_valid_o), .rec_ready_i(rec_ready_i),
        .rec_byte_o(rec_byte_o), .rec_copy_o(rec_copy_o), .rec_index_o(rec_index_o),
        .rec_last_o(rec_last_o));
    sdm_sink sink (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .slow_i(slow),
        .ready_o(rec_ready_i));
    initial begin
        forever #2.5 clk_sys_i = ~clk_sys_i;
    end
    // ==========================================
    // Tasks and record model
    task automatic chk(input [31:0] seen, input [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            failures++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input [7:0] ad, input [31:0] dt);
        reg_addr_i <= ad;
        reg_wdata_i <= dt;
        reg_wr_i <= 1'b1;
        @(posedge clk_sys_i);
        reg_wr_i <= 1'b0;
        @(posedge clk_sys_i);
    endtask
    task automatic rd(input [7:0] ad, output [31:0] q);
        reg_addr_i <= ad;
        reg_rd_i <= 1'b1;
        @(posedge clk_sys_i);
        reg_rd_i <= 1'b0;
        @(negedge clk_sys_i);
        q = reg_rdata_o;
        @(posedge clk_sys_i);
    endtask
    task automatic rc(input [7:0] ad, input [31:0] exp);
        logic [31:0] q;
        rd(ad, q);
        chk(q, exp);
    endtask
    task automatic stop_test;
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    function automatic [7:0] exp_byte(input int x, input int c, input [31:0] p, input [31:0] s);
        if (x < 2) exp_byte = 8'h0a;
        else if (x == 3) exp_byte = c ? 8'h01 : 8'h02;
        else if (x == 5) exp_byte = 8'h13;
        else if (x >= 14 && x <= 17) exp_byte = p[8 * (17 - x) +: 8];
        else if (x >= 18 && x <= 21) exp_byte = s[8 * (21 - x) +: 8];
        else if (x >= 22 && x <= 40) exp_byte = 8'h01;
        else exp_byte = 8'h00;
    endfunction
    // ==========================================
    // Watchdog and main sequence
    initial begin
        #400us;
        failures++;
        stop_test;
    end
    initial begin
        v = $urandom(97);
        repeat (3) @(posedge clk_sys_i);
        rst_n_i <= 1'b1;
        @(posedge clk_sys_i);
        rc(8'h40, 32'h0);
        for (k = 0; k < 2; k++) begin
            a = $urandom;
            d = $urandom;
            slow <= k[0];
            wr(8'h08, a);
            wr(8'h0c, d);
            wr(8'h00, 1 - k);
            // GO inline: the first byte may be taken one edge after it
            reg_wdata_i <= 3 - k;
            reg_wr_i <= 1'b1;
            @(posedge clk_sys_i);
            reg_wr_i <= 1'b0;
            for (n = 0, i = 0; n < 8192 && i < 40000; i++) begin
                @(negedge clk_sys_i);
                if (rec_valid_o === 1'b1 && rec_ready_i === 1'b1) begin
                    chk(rec_byte_o, exp_byte(n % 2048, 1 - k, a, d));
                    chk({rec_copy_o, rec_index_o}, n);
                    n++;
                end
            end
            @(posedge clk_sys_i);
            chk(n, 8192);
            $display("record test %0d done", k);
        end
        // Uncertified disk: a replacement that fails gets a second spare
        sp = {24'd1000, 8'd0};
        a = {24'd100, 8'd3};
        wr(8'h00, 32'h4);
        wr(8'h10, 0);
        wr(8'h14, sp);
        wr(8'h18, 4);
        wr(8'h1c, a);
        wr(8'h1c, sp);
        sk = '{a, a};
        sr = '{sp, sp + 1};
        for (i = 0; i < 2; i++) begin
            wr(8'h30, i);
            rc(8'h38, sk[i]);
            rc(8'h3c, sr[i]);
        end
        wr(8'h24, a);
        rc(8'h28, sr[$]);
        $display("linear test done");
        // Certification: repeated defect and bad spare
        d = {24'd5000, 8'd2};
        sp = {24'd6000, 8'd0};
        wr(8'h00, 32'hd);
        wr(8'h10, 1);
        wr(8'h14, sp);
        wr(8'h18, 3);
        wr(8'h1c, d);
        wr(8'h1c, d);
        wr(8'h2c, sp + 4);
        pq = '{d, sp + 4};
        rc(8'h18, 1);
        rd(8'h04, v);
        chk(v[14:5], 10'h002);
        for (i = 0; i < 3; i++) begin
            wr(8'h30, i);
            rc(8'h34, i < pq.size() ? pq[i] : 32'hffffffff);
        end
        for (k = 0; k < 2; k++) begin
            wr(8'h24, d - 1 + k);
            rc(8'h28, d - 1 + 2 * k);
        end
        wr(8'h1c, {24'd4000, 8'd0});
        wr(8'h1c, {24'd2, 8'd16});
        rd(8'h04, v);
        chk(v[3:1], 3'b101);
        wr(8'h04, 32'ha);
        wr(8'h10, 18);
        wr(8'h1c, d + 8);
        rd(8'h04, v);
        chk(v[3:1], 3'b001);
        wr(8'h10, 1);
        wr(8'h18, 0);
        wr(8'h1c, d + 1);
        wr(8'h20, 1);
        wr(8'h1c, d + 1);
        rd(8'h04, v);
        chk(v[14:4], 11'h045);
        wr(8'h30, 0);
        rc(8'h3c, {24'd1000, 8'd2});
        $display("certify test done");
        stop_test;
    end
endmodule // test_sector_defect_manager

bind sdm_top sdm_monitor mon (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
    .rec_valid_o(rec_valid_o), .rec_ready_i(rec_ready_i), .rec_byte_o(rec_byte_o),
    .rec_copy_o(rec_copy_o), .rec_index_o(rec_index_o), .rec_last_o(rec_last_o));
